// [rpit_consts.vh]
// register offsets, field positions, reset values and timing counts
// for the periodic interrupt timer; definitions only
`ifndef RPIT_CONSTS_VH
`define RPIT_CONSTS_VH
// register indices on the apb bus (printed offsets are not all multiples of
// four, so each printed offset is an index and the address is 4x it)
`define RPIT_IDX_CMP_LO     8'h08
`define RPIT_IDX_CMP_HI     8'h09
`define RPIT_IDX_CTRL       8'h10
`define RPIT_IDX_STATUS     8'h11
`define RPIT_IDX_IRQ_EN     8'h12
`define RPIT_IDX_IRQ_FLAG   8'h13
`define RPIT_IDX_IRQ_MASK   8'h14
`define RPIT_IDX_IRQ_STAT   8'h16
// control fields
`define RPIT_EN_BIT         0
`define RPIT_PER_LSB        3
`define RPIT_PER_MSB        6
`define RPIT_CTRL_MASK      8'h79
`define RPIT_PER_OFF        4'h0
`define RPIT_PER_MAX        4'hE
// reset values
`define RPIT_CTRL_RST       8'h00
`define RPIT_CMP_RST        16'h0000
`define RPIT_MASK_RST       2'h0
// synchroniser depth for the rtc clock input
`define RPIT_SYNC_STAGES    2
// rtc ticks a control write waits before it reaches the timer
`define RPIT_BUSY_TICKS     3'h2
`endif

// [rpit_sync.v]
// two flip-flop level synchroniser with clock enable
// assumes din is asynchronous to clk
`timescale 1ns/100ps
module rpit_sync (
  input  wire clk,
  input  wire rst_n,
  input  wire ce,
  input  wire din,
  output reg  dout
);
  reg meta;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= 1'b0;
      dout <= 1'b0;
    end else if (ce) begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule

// [rpit_div.v]
// free counter of rtc ticks with period select
// assumes tick is a one-cycle pulse per rising rtc clock edge in the pclk domain
`timescale 1ns/100ps
`include "rpit_consts.vh"
module rpit_div #(
  parameter WIDTH = 15
) (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       ce,
  input  wire       run,
  input  wire       tick,
  input  wire [3:0] period,
  output reg        fire
);
  reg  [WIDTH-1:0] cnt;
  wire [WIDTH:0]   span;
  wire [WIDTH-1:0] last;

  // span is 2^(period+1); last count value is span-1
  assign span = {{WIDTH{1'b0}}, 1'b1} << (period + 4'h1);
  assign last = span[WIDTH-1:0] - {{(WIDTH-1){1'b0}}, 1'b1};

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt  <= {WIDTH{1'b0}};
      fire <= 1'b0;
    end else if (ce) begin
      fire <= 1'b0;
      if (!run) begin
        cnt <= {WIDTH{1'b0}};
      end else if (tick) begin
        if (cnt == last) begin
          cnt  <= {WIDTH{1'b0}};
          fire <= 1'b1;
        end else begin
          cnt <= cnt + {{(WIDTH-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule

// [rpit_top.v]
// periodic interrupt timer with compare value register, apb slave
// assumes rtc_clk is a slow free-running clock, far below pclk
//
// The APB register port was decided locally.
`timescale 1ns/100ps
`include "rpit_consts.vh"
module rpit_top (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        pce,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        rtc_clk,
  output reg  [15:0] compare_value,
  output reg         periodic_irq,
  output reg         irq
);
  reg  [7:0]  periodic_timer_control;
  reg  [7:0]  live_ctrl;
  reg         periodic_irq_enable_reg;
  reg         periodic_irq_flag_reg;
  reg  [1:0]  irq_mask;
  reg  [1:0]  irq_status;
  reg         control_sync_busy;
  reg  [2:0]  busy_cnt;
  reg         rtc_prev;
  reg  [31:0] next_prdata;
  reg         next_err;
  wire        rtc_lvl;
  wire        rtc_tick;
  wire        fire;
  wire        acc;
  wire        wr;
  wire        rd;
  wire [9:0]  idx;
  wire        addr_ok;
  wire        run;
  wire        wr_byte;
  wire        sel_cmp_lo;
  wire        sel_cmp_hi;
  wire        sel_ctrl;
  wire        sel_irq_en;
  wire        sel_irq_flag;
  wire        sel_irq_mask;
  wire        sel_irq_stat;
  wire        sync_done;
  wire [1:0]  irq_events;
  wire        flag_clear;

  assign acc = psel & penable & pce & ~pready;
  // a refused address must not write anything, misaligned ones included
  assign wr  = acc & pwrite & addr_ok;
  assign rd  = acc & ~pwrite;

  assign sel_cmp_lo   = (idx == {2'h0, `RPIT_IDX_CMP_LO});
  assign sel_cmp_hi   = (idx == {2'h0, `RPIT_IDX_CMP_HI});
  assign sel_ctrl     = (idx == {2'h0, `RPIT_IDX_CTRL});
  assign sel_irq_en   = (idx == {2'h0, `RPIT_IDX_IRQ_EN});
  assign sel_irq_flag = (idx == {2'h0, `RPIT_IDX_IRQ_FLAG});
  assign sel_irq_mask = (idx == {2'h0, `RPIT_IDX_IRQ_MASK});
  assign sel_irq_stat = (idx == {2'h0, `RPIT_IDX_IRQ_STAT});
  assign wr_byte      = wr & pstrb[0];
  assign sync_done    = control_sync_busy & rtc_tick & (busy_cnt == 3'h1);
  assign irq_events   = {sync_done, fire};
  assign flag_clear   = wr_byte & sel_irq_flag & pwdata[0];
  assign idx = paddr[11:2];
  assign addr_ok = (paddr[1:0] == 2'h0) &&
    (idx == {2'h0, `RPIT_IDX_CMP_LO} || idx == {2'h0, `RPIT_IDX_CMP_HI} ||
     idx == {2'h0, `RPIT_IDX_CTRL}   || idx == {2'h0, `RPIT_IDX_STATUS} ||
     idx == {2'h0, `RPIT_IDX_IRQ_EN} || idx == {2'h0, `RPIT_IDX_IRQ_FLAG} ||
     idx == {2'h0, `RPIT_IDX_IRQ_MASK} ||
     idx == {2'h0, `RPIT_IDX_IRQ_STAT});

  rpit_sync u_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .ce    (pce),
    .din   (rtc_clk),
    .dout  (rtc_lvl)
  );

  assign rtc_tick = rtc_lvl & ~rtc_prev;
  // reserved period 15 is treated like off so nothing fires
  assign run = live_ctrl[`RPIT_EN_BIT] &&
    live_ctrl[`RPIT_PER_MSB:`RPIT_PER_LSB] != `RPIT_PER_OFF &&
    live_ctrl[`RPIT_PER_MSB:`RPIT_PER_LSB] <= `RPIT_PER_MAX;

  rpit_div #(
    .WIDTH (15)
  ) u_div (
    .clk    (pclk),
    .rst_n  (presetn),
    .ce     (pce),
    .run    (run),
    .tick   (rtc_tick),
    .period (live_ctrl[`RPIT_PER_MSB:`RPIT_PER_LSB]),
    .fire   (fire)
  );

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rtc_prev <= 1'b0;
    end else if (pce) begin
      rtc_prev <= rtc_lvl;
    end
  end

  // control write lands in the rtc domain after two rtc ticks; busy covers
  // that latency so software knows when the new setting took effect
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_sync_busy <= 1'b0;
      busy_cnt          <= 3'h0;
    end else if (pce) begin
      if (wr_byte && sel_ctrl) begin
        // a rewrite while busy restarts the wait with the newer value
        control_sync_busy <= 1'b1;
        busy_cnt          <= `RPIT_BUSY_TICKS;
      end else if (control_sync_busy && rtc_tick) begin
        if (busy_cnt == 3'h1) begin
          control_sync_busy <= 1'b0;
        end
        busy_cnt <= busy_cnt - 3'h1;
      end
    end
  end

  // the timer only ever sees the settled copy, never a half-written one
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      live_ctrl <= `RPIT_CTRL_RST;
    end else if (pce) begin
      if (sync_done) begin
        live_ctrl <= periodic_timer_control;
      end
    end
  end

  // both bytes are plain registers; no latching between the two halves
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_value <= `RPIT_CMP_RST;
    end else if (pce) begin
      if (wr_byte && sel_cmp_lo) begin
        compare_value[7:0] <= pwdata[7:0];
      end
      if (wr_byte && sel_cmp_hi) begin
        compare_value[15:8] <= pwdata[7:0];
      end
    end
  end

  // reserved control bits are dropped on write so they always read zero
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periodic_timer_control <= `RPIT_CTRL_RST;
    end else if (pce) begin
      if (wr_byte && sel_ctrl) begin
        periodic_timer_control <= pwdata[7:0] & `RPIT_CTRL_MASK;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periodic_irq_enable_reg <= 1'b0;
    end else if (pce) begin
      if (wr_byte && sel_irq_en) begin
        periodic_irq_enable_reg <= pwdata[0];
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask <= `RPIT_MASK_RST;
    end else if (pce) begin
      if (wr_byte && sel_irq_mask) begin
        irq_mask <= pwdata[1:0];
      end
    end
  end

  // set wins over a same-cycle clear so no interval is ever lost
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periodic_irq_flag_reg <= 1'b0;
    end else if (pce) begin
      if (fire) begin
        periodic_irq_flag_reg <= 1'b1;
      end else if (flag_clear) begin
        periodic_irq_flag_reg <= 1'b0;
      end
    end
  end

  // sticky events: bit0 periodic fire, bit1 control sync done; an event
  // landing in the read cycle survives the clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= 2'h0;
    end else if (pce) begin
      if (rd && addr_ok && sel_irq_stat) begin
        irq_status <= irq_events;
      end else begin
        irq_status <= irq_status | irq_events;
      end
    end
  end

  // forwarded periodic request: the flag gated by its enable bit
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periodic_irq <= 1'b0;
    end else if (pce) begin
      periodic_irq <= periodic_irq_flag_reg &
                      periodic_irq_enable_reg;
    end
  end

  // summary line: high while any unmasked sticky bit is set
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else if (pce) begin
      irq <= |(irq_status & irq_mask);
    end
  end

  always @* begin
    next_prdata = 32'h0000_0000;
    next_err    = ~addr_ok;
    case (idx)
      {2'h0, `RPIT_IDX_CMP_LO}: begin
        next_prdata[7:0] = compare_value[7:0];
      end
      {2'h0, `RPIT_IDX_CMP_HI}: begin
        next_prdata[7:0] = compare_value[15:8];
      end
      {2'h0, `RPIT_IDX_CTRL}: begin
        next_prdata[7:0] = periodic_timer_control;
      end
      {2'h0, `RPIT_IDX_STATUS}: begin
        next_prdata[0] = control_sync_busy;
      end
      {2'h0, `RPIT_IDX_IRQ_EN}: begin
        next_prdata[0] = periodic_irq_enable_reg;
      end
      {2'h0, `RPIT_IDX_IRQ_FLAG}: begin
        next_prdata[0] = periodic_irq_flag_reg;
      end
      {2'h0, `RPIT_IDX_IRQ_MASK}: begin
        next_prdata[1:0] = irq_mask;
      end
      {2'h0, `RPIT_IDX_IRQ_STAT}: begin
        next_prdata[1:0] = irq_status;
      end
      default: begin
        next_prdata = 32'h0000_0000;
      end
    endcase
  end

  // one wait state: pready rises the cycle after the access phase starts
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (pce) begin
      pready  <= acc;
      pslverr <= acc & next_err;
    end
  end

  // read data holds until the next read, so a slow master may still see it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (pce) begin
      if (rd) begin
        prdata <= next_err ? 32'h0000_0000 : next_prdata;
      end
    end
  end
endmodule

// [rpit_chk.sv]
// port assertions for the periodic interrupt timer
// assumes one pclk domain; bound to every rpit_top instance
`timescale 1ns/100ps
module rpit_chk (
  input wire        pclk,
  input wire        presetn,
  input wire        pce,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0]  pstrb,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire [15:0] compare_value,
  input wire        periodic_irq,
  input wire        irq
);
  wire tk = psel & penable & pce & ~pready;
  wire wr = tk & pwrite & pstrb[0];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_cmp_hi;
    wr && paddr == 12'h024 |=> compare_value[15:8] == $past(pwdata[7:0]);
  endproperty
  a_cmp_hi: assert property (p_cmp_hi) else $error("compare high wrong");
  property p_cmp_lo;
    wr && paddr == 12'h020 |=> compare_value[7:0] == $past(pwdata[7:0]);
  endproperty
  a_cmp_lo: assert property (p_cmp_lo) else $error("compare low wrong");
  property p_cmp_hold; !wr |=> $stable(compare_value); endproperty
  a_cmp_hold: assert property (p_cmp_hold) else $error("compare moved");
  property p_ready; tk |=> pready ##1 !pready; endproperty
  a_ready: assert property (p_ready) else $error("pready not one pulse");
  property p_unmap;
    tk && paddr == 12'h03C |=> pslverr && (pwrite || prdata == 32'h0);
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped not refused");
  property p_ctrl_rd;
    tk && !pwrite && paddr == 12'h040 |=> (prdata & ~32'h79) == 32'h0;
  endproperty
  a_ctrl_rd: assert property (p_ctrl_rd) else $error("ctrl reserved set");
  property p_stat_rd;
    tk && !pwrite && paddr == 12'h044 |=> prdata[31:1] == 31'h0;
  endproperty
  a_stat_rd: assert property (p_stat_rd) else $error("status extra bits");
  property p_ien_off;
    wr && paddr == 12'h048 && !pwdata[0] |-> ##2 !periodic_irq;
  endproperty
  a_ien_off: assert property (p_ien_off) else $error("irq not gated");
  c_cmp: cover property (wr && paddr == 12'h024);
  c_pirq: cover property ($rose(periodic_irq));
  c_irq: cover property ($rose(irq));
endmodule
bind rpit_top rpit_chk u_chk (.*);

// [rtc_periodic_interrupt_timer_tb.sv]
// self-checking bench for the periodic interrupt timer
// drives apb and an rtc clock at 1/8 of pclk; checker bound apart
`timescale 1ns/100ps
module rtc_periodic_interrupt_timer_tb;
  reg         pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  reg         rtc_clk = 0, rerr;
  reg  [11:0] paddr = 12'h000;
  reg  [31:0] pwdata = 32'h0, rdat;
  reg  [2:0]  rdiv = 3'h0;
  wire [31:0] prdata;
  wire [15:0] compare_value;
  wire        pready, pslverr, periodic_irq, irq;
  integer     error_cnt = 0, compares = 0, p;
  time        t0;
  rpit_top uut (.pclk(pclk), .presetn(presetn), .pce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rtc_clk(rtc_clk), .compare_value(compare_value),
    .periodic_irq(periodic_irq), .irq(irq));
  initial forever #25 pclk = ~pclk;
  // slow rtc keeps sync waits and intervals short but still multi-cycle
  always @(posedge pclk) begin
    rdiv <= rdiv + 3'h1;
    if (rdiv[1:0] == 2'h3) rtc_clk <= ~rtc_clk;
  end
  task chk(input [31:0] got, input [31:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task xfer(input [11:0] a, input w, input [7:0] d);
    begin
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask
  task rd(input [11:0] a, input [31:0] exp);
    begin
      xfer(a, 1'b0, 8'h00);
      chk(rdat, exp);
    end
  endtask
  task quiet(input [7:0] c);
    begin
      xfer(12'h040, 1'b1, c);
      repeat (40) @(posedge pclk);
      xfer(12'h04C, 1'b1, 8'h01);
      repeat (300) @(posedge pclk);
      chk(periodic_irq, 1'b0);
    end
  endtask
  task report_and_stop;
    begin
      if (error_cnt == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  initial begin
    #1000000;
    error_cnt = error_cnt + 1;
    report_and_stop;
  end
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(12'h040, 32'h0);
    rd(12'h044, 32'h0);
    xfer(12'h020, 1'b1, 8'hA5);
    xfer(12'h024, 1'b1, 8'h3C);
    chk({16'h0, compare_value}, 32'h3CA5);
    xfer(12'h022, 1'b1, 8'hFF);
    chk(rerr, 1'b1);
    chk({16'h0, compare_value}, 32'h3CA5);
    rd(12'h024, 32'h3C);
    rd(12'h03C, 32'h0);
    chk(rerr, 1'b1);
    xfer(12'h040, 1'b1, 8'hFF);
    rd(12'h044, 32'h1);
    rd(12'h040, 32'h79);
    repeat (40) @(posedge pclk);
    rd(12'h044, 32'h0);
    xfer(12'h048, 1'b1, 8'h01);
    xfer(12'h050, 1'b1, 8'h01);
    for (p = 1; p <= 3; p = p + 1) begin
      xfer(12'h040, 1'b1, {1'b0, p[3:0], 3'h1});
      repeat (40) @(posedge pclk);
      xfer(12'h04C, 1'b1, 8'h01);
      @(posedge periodic_irq);
      t0 = $time;
      xfer(12'h04C, 1'b1, 8'h01);
      chk(periodic_irq, 1'b0);
      @(posedge periodic_irq);
      chk(($time - t0) / 50, 32'd8 << (p + 1));
      repeat (2) @(posedge pclk);
      chk(irq, 1'b1);
      xfer(12'h058, 1'b0, 8'h00);
      chk(rdat[0], 1'b1);
      chk(irq, 1'b0);
    end
    xfer(12'h050, 1'b1, 8'h00);
    repeat (300) @(posedge pclk);
    chk(irq, 1'b0);
    xfer(12'h048, 1'b1, 8'h00);
    repeat (200) @(posedge pclk);
    chk(periodic_irq, 1'b0);
    xfer(12'h048, 1'b1, 8'h01);
    chk(periodic_irq, 1'b1);
    quiet(8'h01);
    quiet(8'h08);
    quiet(8'h79);
    report_and_stop;
  end
endmodule
